// [include/crpc_consts.svh]
/*
 * crpc_consts.svh: offsets, field positions, reset values and timing
 * counts for the clock, tick and reset control block.
 * Assumes a 20 MHz system clock (clk_sys_i) for all cycle counts.
 */
`ifndef CRPC_CONSTS_SVH
`define CRPC_CONSTS_SVH

// register offset on the special-function register bus
`define CRPC_CLK_CTRL_ADDR 8'hc6

// field positions of clock_source_and_tick_control
`define CRPC_LF_SEL_BIT 7
`define CRPC_SYS_SEL_BIT 6
`define CRPC_TICK_HI 5
`define CRPC_TICK_LO 3
`define CRPC_SPEED_BIT 0

// reset values
`define CRPC_LF_SEL_RST 1'h1
`define CRPC_SYS_SEL_RST 1'h1
`define CRPC_TICK_RST 3'h1
`define CRPC_SPEED_RST 1'h1
`define CRPC_UNUSED_OSCILLATOR_POWER_DOWN_RST 1'h1
`define CRPC_WDOG_RST 15'h0000

// reset-cause codes
`define CRPC_CAUSE_POWER 2'h0
`define CRPC_CAUSE_PIN 2'h1
`define CRPC_CAUSE_WDOG 2'h2

// retained data memory window
`define CRPC_KEEP_LO 16'hf000
`define CRPC_KEEP_HI 16'hffff
`define CRPC_LOSE_A_LO 16'he000
`define CRPC_LOSE_A_HI 16'hefff
`define CRPC_LOSE_B_LO 16'hfd56
`define CRPC_LOSE_B_HI 16'hfeff

// timing: system clock and crystal settle guard
`define CRPC_CLK_MHZ 20
`define CRPC_XTAL_GUARD_US 64
`define CRPC_XTAL_GUARD_CYC (`CRPC_XTAL_GUARD_US * `CRPC_CLK_MHZ)

`endif

// [include/crpc_pkg.sv]
/*
 * crpc_pkg: types shared by the clock, tick and reset control files.
 * Assumes crpc_consts.svh is on the include path.
 */
package crpc_pkg;
   // high-frequency clock switch sequence
   typedef enum logic [1:0] {
      SW_IDLE,
      SW_WAIT_STABLE,
      SW_GATE
   } crpc_sw_state_t;

   // reset cause code
   typedef logic [1:0] crpc_cause_t;
   // tick rate code
   typedef logic [2:0] crpc_tick_code_t;
endpackage : crpc_pkg

// [rtl/crpc_sync2.sv]
/*
 * crpc_sync2: two-flop synchroniser for one level from another domain.
 * Assumes the input is a level that holds for several clocks.
 */
`timescale 1ns/1ns
module crpc_sync2 #(
   parameter logic RST_VAL = 1'b0
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // level in and out
   input wire logic async_i,
   output logic sync_o
);
   logic stage1;
   logic next_stage1;
   logic next_sync;

   // first stage feeds only the second
   always_comb begin
      next_stage1 = async_i;
      next_sync = stage1;
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         stage1 <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         stage1 <= next_stage1;
         sync_o <= next_sync;
      end
   end
endmodule : crpc_sync2

// [rtl/crpc_tick_gen.sv]
/*
 * crpc_tick_gen: shared timer prescaler. A one-cycle enable pulse is
 * produced every 2**code cycles of the 32 MHz reference count.
 * Assumes ref_en_i marks one reference-clock period in the system clock.
 */
`timescale 1ns/1ns
module crpc_tick_gen
   import crpc_pkg::*;
#(
   parameter int CODE_W = 3
) (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // control
   input wire logic ref_en_i,
   input wire crpc_pkg::crpc_tick_code_t code_i,
   // tick out
   output logic tick_o
);
   localparam int DIV_W = (1 << CODE_W) - 1;
   logic [DIV_W-1:0] div;
   logic [DIV_W-1:0] next_div;
   logic next_tick;
   logic [DIV_W-1:0] mask;

   // the code port is a fixed 3-bit type, so refuse anything else
   if (CODE_W != 3) begin : g_bad_code_w
      $error("crpc_tick_gen supports a 3-bit code only");
   end

   // a tick when the low code bits of the divider are all zero
   always_comb begin
      mask = DIV_W'((1 << code_i) - 1);
      next_div = div;
      next_tick = 1'b0;
      if (ref_en_i) begin
         next_div = div + 1'b1;
         next_tick = ((div & mask) == '0);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         div <= '0;
         tick_o <= 1'b0;
      end else begin
         div <= next_div;
         tick_o <= next_tick;
      end
   end
endmodule : crpc_tick_gen

// [rtl/crpc_clock_reset_ctrl.sv]
/*
 * crpc_clock_reset_ctrl: clock source selection, timer tick enable,
 * deep-sleep retention effects and reset source handling.
 * Assumes oscillator status, detectors and the reset pin come from
 * outside the clock domain; the SFR bus is on clk_sys_i.
 */
`timescale 1ns/1ns
`include "crpc_consts.svh"
module crpc_clock_reset_ctrl
   import crpc_pkg::*;
#(
   parameter int GUARD_CYC = `CRPC_XTAL_GUARD_CYC,
   parameter int SW_SYNC_CYC = 4
) (
   // clock and synchronous reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // special-function register port
   input wire logic [7:0] sfr_addr_i,
   input wire logic sfr_wr_i,
   input wire logic [7:0] sfr_wdata_i,
   output logic [7:0] sfr_rdata_o,
   // sleep controls owned by the power-mode logic
   input wire logic unused_oscillator_power_down_i,
   input wire logic low_freq_rc_calibration_disable_i,
   input wire logic deep_entry_i,
   input wire logic deep_exit_i,
   // oscillator status from the analog side
   input wire logic crystal_stable_flag_i,
   input wire logic rc_hf_stable_i,
   input wire logic ref32_en_i,
   input wire logic lf_cal_busy_i,
   // reset sources
   input wire logic ext_rst_n_i,
   input wire logic por_ok_i,
   input wire logic brown_out_detector_ok_i,
   input wire logic wdog_timeout_i,
   // data memory retention query
   input wire logic [15:0] mem_addr_i,
   output logic mem_retained_o,
   // oscillator controls
   output logic high_freq_crystal_pd_o,
   output logic rc_hf_pd_o,
   output logic sys_clk_use_rc_o,
   output logic sys_clk_gate_o,
   output logic low_freq_source_select_o,
   output logic lf_cal_enable_o,
   // tick and retention effects
   output logic timer_tick_o,
   output logic radio_queue_flush_o,
   output logic wdog_clear_o,
   // reset outputs
   output logic chip_rst_o,
   output logic [1:0] reset_cause_o,
   output logic pin_pullup_in_o,
   output logic wdog_enable_allow_o,
   output logic [15:0] pc_reset_vec_o
);
   logic xtal_ok_s;
   logic rc_ok_s;
   logic cal_busy_s;
   logic ext_n_s;
   logic por_s;
   logic bod_s;
   logic wdog_s;

   // guard and gate counters are 16 bits wide
   if (GUARD_CYC < 1 || GUARD_CYC > 65536 || SW_SYNC_CYC < 1
      || SW_SYNC_CYC > 65536) begin : g_bad_counts
      $error("crpc_clock_reset_ctrl: counts out of range");
   end

   // pins and analog flags pass two flops first
   crpc_sync2 #(.RST_VAL(1'b0)) u_sync_xtal (.clk_sys_i(clk_sys_i),
      .srst_i(srst_i), .async_i(crystal_stable_flag_i), .sync_o(xtal_ok_s));
   crpc_sync2 #(.RST_VAL(1'b1)) u_sync_rc (.clk_sys_i(clk_sys_i),
      .srst_i(srst_i), .async_i(rc_hf_stable_i), .sync_o(rc_ok_s));
   crpc_sync2 #(.RST_VAL(1'b0)) u_sync_cal (.clk_sys_i(clk_sys_i),
      .srst_i(srst_i), .async_i(lf_cal_busy_i), .sync_o(cal_busy_s));
   crpc_sync2 #(.RST_VAL(1'b1)) u_sync_ext (.clk_sys_i(clk_sys_i),
      .srst_i(1'b0), .async_i(ext_rst_n_i), .sync_o(ext_n_s));
   crpc_sync2 #(.RST_VAL(1'b0)) u_sync_por (.clk_sys_i(clk_sys_i),
      .srst_i(1'b0), .async_i(por_ok_i), .sync_o(por_s));
   crpc_sync2 #(.RST_VAL(1'b0)) u_sync_bod (.clk_sys_i(clk_sys_i),
      .srst_i(1'b0), .async_i(brown_out_detector_ok_i), .sync_o(bod_s));
   crpc_sync2 #(.RST_VAL(1'b0)) u_sync_wd (.clk_sys_i(clk_sys_i),
      .srst_i(1'b0), .async_i(wdog_timeout_i), .sync_o(wdog_s));

   // reset sources: the four source synchronisers above use no reset so they keep
   // watching while the chip reset is asserted
   logic power_bad;
   logic any_rst;
   crpc_cause_t cause;
   crpc_cause_t next_cause;
   logic next_chip_rst;

   always_comb begin
      power_bad = !por_s || !bod_s;
      any_rst = power_bad || !ext_n_s || wdog_s || srst_i;
      next_chip_rst = any_rst;
      next_cause = cause;
      // fixed priority: power over pin over watchdog; brown-out shares the power-on code
      if (power_bad)
         next_cause = `CRPC_CAUSE_POWER;
      else if (!ext_n_s)
         next_cause = `CRPC_CAUSE_PIN;
      else if (wdog_s)
         next_cause = `CRPC_CAUSE_WDOG;
   end

   // cause register is never cleared by the reset it records
   always_ff @(posedge clk_sys_i) begin
      chip_rst_o <= next_chip_rst;
      cause <= next_cause;
   end

   // initial conditions driven while and after reset
   always_comb begin
      reset_cause_o = cause;
      pin_pullup_in_o = chip_rst_o;
      wdog_enable_allow_o = !chip_rst_o;
      pc_reset_vec_o = 16'h0000;
   end

   // control register state
   logic lf_sel;
   logic sys_sel;
   crpc_tick_code_t tick_code;
   logic speed;
   logic next_lf_sel;
   logic next_sys_sel;
   crpc_tick_code_t next_tick_code;
   logic next_speed;
   logic reg_wr;
   logic rc_force_on;
   logic next_rc_force_on;

   // clock switch sequencer
   crpc_sw_state_t sw_state;
   crpc_sw_state_t next_sw_state;
   logic use_rc;
   logic next_use_rc;
   logic [15:0] guard_cnt;
   logic [15:0] next_guard_cnt;
   logic gate;
   logic next_gate;
   logic target_ok;

   always_comb begin
      reg_wr = sfr_wr_i && (sfr_addr_i == `CRPC_CLK_CTRL_ADDR);
      next_lf_sel = lf_sel;
      next_sys_sel = sys_sel;
      next_tick_code = tick_code;
      next_rc_force_on = rc_force_on;
      // clear first so a fresh revive request in the same cycle wins
      if (rc_ok_s && use_rc)
         next_rc_force_on = 1'b0;
      if (reg_wr) begin
         // low-frequency select honoured only while on the RC clock
         if (use_rc)
            next_lf_sel = sfr_wdata_i[`CRPC_LF_SEL_BIT];
         next_sys_sel = sfr_wdata_i[`CRPC_SYS_SEL_BIT];
         next_tick_code = sfr_wdata_i[`CRPC_TICK_HI:`CRPC_TICK_LO];
         if (sfr_wdata_i[`CRPC_SYS_SEL_BIT])
            next_rc_force_on = 1'b1;
      end
      // bit 7 is lost in deep modes; all other bits are kept
      if (deep_exit_i)
         next_lf_sel = `CRPC_LF_SEL_RST;
   end

   // the target is powered when selected or when power-down is off
   always_comb begin
      target_ok = sys_sel ? rc_ok_s : xtal_ok_s;
      next_sw_state = sw_state;
      next_use_rc = use_rc;
      next_guard_cnt = guard_cnt;
      next_gate = gate;
      next_speed = speed;
      case (sw_state)
         SW_IDLE: begin
            if (sys_sel != use_rc) begin
               next_sw_state = SW_WAIT_STABLE;
               next_guard_cnt = '0;
            end
         end
         SW_WAIT_STABLE: begin
            // an extra guard after crystal stable protects careless code
            if (sys_sel == use_rc) begin
               next_sw_state = SW_IDLE;
            end else if (!target_ok) begin
               next_guard_cnt = '0;
            end else if (sys_sel || guard_cnt >= 16'(GUARD_CYC - 1)) begin
               next_sw_state = SW_GATE;
               next_gate = 1'b1;
               next_guard_cnt = '0;
            end else begin
               next_guard_cnt = guard_cnt + 16'h0001;
            end
         end
         SW_GATE: begin
            // output held low while both domains settle
            if (guard_cnt >= 16'(SW_SYNC_CYC - 1)) begin
               next_use_rc = sys_sel;
               next_speed = sys_sel;
               next_gate = 1'b0;
               next_sw_state = SW_IDLE;
            end else begin
               next_guard_cnt = guard_cnt + 16'h0001;
            end
         end
         default: next_sw_state = SW_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys_i) begin
      if (chip_rst_o) begin
         lf_sel <= `CRPC_LF_SEL_RST;
         sys_sel <= `CRPC_SYS_SEL_RST;
         tick_code <= `CRPC_TICK_RST;
         speed <= `CRPC_SPEED_RST;
         rc_force_on <= 1'b0;
         sw_state <= SW_IDLE;
         use_rc <= 1'b1;
         guard_cnt <= '0;
         gate <= 1'b0;
      end else begin
         lf_sel <= next_lf_sel;
         sys_sel <= next_sys_sel;
         tick_code <= next_tick_code;
         speed <= next_speed;
         rc_force_on <= next_rc_force_on;
         sw_state <= next_sw_state;
         use_rc <= next_use_rc;
         guard_cnt <= next_guard_cnt;
         gate <= next_gate;
      end
   end

   // register read: reserved bits 2:1 read zero
   logic [7:0] rd_word;
   always_comb begin
      rd_word = {lf_sel, sys_sel, tick_code, 2'h0, speed};
   end

   // calibration stop takes effect only once idle
   logic cal_en;
   logic next_cal_en;
   logic pd_hold;
   logic next_pd_hold;
   always_comb begin
      next_cal_en = cal_en;
      if (!low_freq_rc_calibration_disable_i)
         next_cal_en = 1'b1;
      else if (!cal_busy_s)
         next_cal_en = 1'b0;
      // power-down request also waits out a running calibration
      next_pd_hold = pd_hold;
      if (!cal_busy_s)
         next_pd_hold = unused_oscillator_power_down_i;
   end

   // oscillator enables and deep-entry side effects
   logic next_xtal_pd;
   logic next_rc_pd;
   logic next_flush;
   logic next_wd_clr;
   logic next_retained;
   always_comb begin
      // unselected oscillator stops only when power-down is set; a
      // pending switch keeps the target running
      next_xtal_pd = pd_hold && use_rc && sys_sel;
      next_rc_pd = pd_hold && !use_rc && !sys_sel
         && !rc_force_on;
      next_flush = deep_entry_i;
      next_wd_clr = deep_entry_i;
      next_retained = (mem_addr_i >= `CRPC_KEEP_LO)
         && !((mem_addr_i >= `CRPC_LOSE_B_LO)
         && (mem_addr_i <= `CRPC_LOSE_B_HI));
   end

   always_ff @(posedge clk_sys_i) begin
      if (chip_rst_o) begin
         cal_en <= 1'b1;
         pd_hold <= `CRPC_UNUSED_OSCILLATOR_POWER_DOWN_RST;
         high_freq_crystal_pd_o <= 1'b1;
         rc_hf_pd_o <= 1'b0;
         radio_queue_flush_o <= 1'b0;
         wdog_clear_o <= 1'b0;
         mem_retained_o <= 1'b0;
         sfr_rdata_o <= 8'h00;
      end else begin
         cal_en <= next_cal_en;
         pd_hold <= next_pd_hold;
         high_freq_crystal_pd_o <= next_xtal_pd;
         rc_hf_pd_o <= next_rc_pd;
         radio_queue_flush_o <= next_flush;
         wdog_clear_o <= next_wd_clr;
         mem_retained_o <= next_retained;
         sfr_rdata_o <= rd_word;
      end
   end

   // tick enable from the 32 MHz reference count
   logic tick;
   crpc_tick_gen #(.CODE_W(3)) u_tick (
      .clk_sys_i(clk_sys_i),
      .srst_i(chip_rst_o),
      .ref_en_i(ref32_en_i),
      .code_i(tick_code),
      .tick_o(tick)
   );

   // direct outputs
   always_comb begin
      timer_tick_o = tick;
      sys_clk_use_rc_o = use_rc;
      sys_clk_gate_o = gate;
      low_freq_source_select_o = lf_sel;
      lf_cal_enable_o = cal_en && !use_rc && xtal_ok_s;
   end
endmodule : crpc_clock_reset_ctrl

// [bench/crpc_chk.sv]
/* crpc_chk: port-level assertions for crpc_clock_reset_ctrl.
   Assumes the default switch sync length of four cycles; bound below. */
`timescale 1ns/1ns
`include "crpc_consts.svh"
module crpc_chk (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // watched inputs
   input wire logic sfr_wr_i,
   input wire logic deep_entry_i,
   input wire logic deep_exit_i,
   input wire logic crystal_stable_flag_i,
   input wire logic ref32_en_i,
   input wire logic lf_cal_busy_i,
   input wire logic ext_rst_n_i,
   input wire logic [15:0] mem_addr_i,
   // watched outputs
   input wire logic [7:0] sfr_rdata_o,
   input wire logic mem_retained_o,
   input wire logic sys_clk_use_rc_o,
   input wire logic sys_clk_gate_o,
   input wire logic low_freq_source_select_o,
   input wire logic lf_cal_enable_o,
   input wire logic timer_tick_o,
   input wire logic radio_queue_flush_o,
   input wire logic wdog_clear_o,
   input wire logic chip_rst_o,
   input wire logic pin_pullup_in_o,
   input wire logic wdog_enable_allow_o,
   input wire logic [15:0] pc_reset_vec_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (srst_i);
   logic keep_now;
   // retained window minus the lost hole near the top
   assign keep_now = mem_addr_i >= `CRPC_KEEP_LO &&
      !(mem_addr_i >= `CRPC_LOSE_B_LO && mem_addr_i <= `CRPC_LOSE_B_HI);

   a_flush_on_entry: assert property (
      deep_entry_i |=> radio_queue_flush_o)
      else $error("queue flush missing after deep entry");
   a_wdog_clear_entry: assert property (
      deep_entry_i |=> wdog_clear_o)
      else $error("watchdog clear missing after deep entry");
   a_reset_state_out: assert property (
      pin_pullup_in_o == chip_rst_o &&
      wdog_enable_allow_o == !chip_rst_o && pc_reset_vec_o == 16'h0000)
      else $error("reset state outputs wrong");
   a_pin_causes_rst: assert property (
      !ext_rst_n_i [*3] |=> chip_rst_o)
      else $error("pin reset not applied in three cycles");
   a_lf_refused_xtal: assert property (
      sfr_wr_i && !sys_clk_use_rc_o && !deep_exit_i |=>
      $stable(low_freq_source_select_o))
      else $error("low freq select changed on crystal clock");
   a_speed_mirror: assert property (
      !chip_rst_o && !$past(chip_rst_o) |->
      sfr_rdata_o[0] == $past(sys_clk_use_rc_o))
      else $error("speed bit does not follow active source");
   a_reserved_zero: assert property (sfr_rdata_o[2:1] == 2'b00)
      else $error("reserved bits not zero");
   a_xtal_needs_stable: assert property (
      !crystal_stable_flag_i [*4] |=> !$fell(sys_clk_use_rc_o))
      else $error("switched to crystal while not stable");
   a_gate_four_cycles: assert property (
      $rose(sys_clk_gate_o) |-> sys_clk_gate_o [*4] ##1 !sys_clk_gate_o)
      else $error("gate length wrong");
   a_switch_at_ungate: assert property (
      $fell(sys_clk_use_rc_o) |-> $fell(sys_clk_gate_o))
      else $error("source changed without gate release");
   a_tick_after_ref: assert property (
      timer_tick_o |-> $past(ref32_en_i))
      else $error("tick without reference pulse");
   a_mem_retain_map: assert property (
      !$past(srst_i) && !$past(chip_rst_o) |->
      mem_retained_o == $past(keep_now))
      else $error("retention flag wrong");
   // busy must be seen past the two-flop delay before the stop counts
   a_cal_finishes: assert property (
      lf_cal_busy_i [*4] ##0 (!chip_rst_o && !$past(chip_rst_o))
      |-> !$fell(lf_cal_enable_o))
      else $error("calibration stopped while busy");

   c_to_crystal: cover property ($fell(sys_clk_use_rc_o));
   c_tick: cover property (timer_tick_o);
   c_deep_entry: cover property (deep_entry_i);
   c_pin_reset: cover property (chip_rst_o && !ext_rst_n_i);
endmodule : crpc_chk

bind crpc_clock_reset_ctrl crpc_chk u_crpc_chk (.*);

// [bench/crpc_clock_reset_ctrl_tb.sv]
/* crpc_clock_reset_ctrl_tb: self-checking bench with a register model.
   Assumes a 20 MHz clock and a shortened crystal guard count. */
`timescale 1ns/1ns
module crpc_clock_reset_ctrl_tb;
   import crpc_pkg::*;
   localparam int GUARD = 8;
   logic clk_sys_i, srst_i, sfr_wr_i, unused_oscillator_power_down, caldis, d_in, d_out;
   logic xstb, rstb, ref_en, busy, rst_n, por_ok, bod_ok, wdt;
   logic kept, xpd, rpd, use_rc, gate, lfsel, cal, tick, flush, wclr;
   logic crst, pull, wallow, spd;
   logic [7:0] addr, wdata, rdata, mdl;
   logic [15:0] maddr, pc;
   logic [1:0] cause;
   logic [15:0] edges [8] = '{16'hf000, 16'hefff, 16'he000, 16'hfd55,
      16'hfd56, 16'hfeff, 16'hff00, 16'hffff};
   logic [1:0] causes [4] = '{2'h1, 2'h0, 2'h0, 2'h2};
   int error_cnt = 0, tests_run = 0, seed = 32'hb208, n, g;

   crpc_clock_reset_ctrl #(.GUARD_CYC(GUARD)) u_crpc_clock_reset_ctrl (
      .clk_sys_i(clk_sys_i), .srst_i(srst_i), .sfr_addr_i(addr),
      .sfr_wr_i(sfr_wr_i), .sfr_wdata_i(wdata), .sfr_rdata_o(rdata),
      .unused_oscillator_power_down_i(unused_oscillator_power_down),
      .low_freq_rc_calibration_disable_i(caldis),
      .deep_entry_i(d_in), .deep_exit_i(d_out),
      .crystal_stable_flag_i(xstb), .rc_hf_stable_i(rstb),
      .ref32_en_i(ref_en), .lf_cal_busy_i(busy), .ext_rst_n_i(rst_n),
      .por_ok_i(por_ok), .brown_out_detector_ok_i(bod_ok),
      .wdog_timeout_i(wdt), .mem_addr_i(maddr), .mem_retained_o(kept),
      .high_freq_crystal_pd_o(xpd), .rc_hf_pd_o(rpd),
      .sys_clk_use_rc_o(use_rc), .sys_clk_gate_o(gate),
      .low_freq_source_select_o(lfsel), .lf_cal_enable_o(cal),
      .timer_tick_o(tick), .radio_queue_flush_o(flush),
      .wdog_clear_o(wclr), .chip_rst_o(crst), .reset_cause_o(cause),
      .pin_pullup_in_o(pull), .wdog_enable_allow_o(wallow),
      .pc_reset_vec_o(pc));

   // 50 ns system clock
   initial begin
      clk_sys_i = 1'b0;
      forever #25 clk_sys_i = ~clk_sys_i;
   end

   // reference pulse every other cycle, well below one per clock
   always @(posedge clk_sys_i) begin
      ref_en <= ~ref_en;
   end

   task check(input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   task results;
      $display("mismatches=%0d checks=%0d", error_cnt, tests_run);
      if (error_cnt == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : results

   task cyc(input int k);
      repeat (k) @(posedge clk_sys_i);
      #1;
   endtask : cyc

   // bounded wait: 0 chip reset, 1 active source, 2 tick
   task wt(input int sel, input logic v, input int lim);
      n = 0;
      while (n < lim && (sel == 0 ? crst : sel == 1 ? use_rc : tick) !== v)
         begin
         cyc(1);
         n++;
      end
      if (n >= lim) begin
         error_cnt++;
         results();
      end
   endtask : wt

   // one write, then the read-back two edges later
   task wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_sys_i);
      sfr_wr_i <= 1'b1;
      addr <= a;
      wdata <= d;
      if (a == 8'hc6 && use_rc === 1'b1) mdl[7] = d[7];
      if (a == 8'hc6) mdl[6:3] = d[6:3];
      @(posedge clk_sys_i);
      sfr_wr_i <= 1'b0;
      cyc(2);
      check(rdata, {mdl[7:3], 2'b00, spd});
   endtask : wr

   // first gap may be a leftover of the old rate, so judge the second
   task tick_gap(input int exp);
      for (int k = 0; k < 2; k++) begin
         wt(2, 1'b1, 600);
         cyc(1);
         g = 1;
         while (tick !== 1'b1 && g < 600) begin
            cyc(1);
            g++;
         end
      end
      check(g, exp);
   endtask : tick_gap

   initial begin
      srst_i = 1'b1; sfr_wr_i = 1'b0; addr = 8'h00; wdata = 8'h00;
      unused_oscillator_power_down = 1'b1; caldis = 1'b0; d_in = 1'b0; d_out = 1'b0;
      xstb = 1'b0; rstb = 1'b1; ref_en = 1'b0; busy = 1'b0;
      rst_n = 1'b1; por_ok = 1'b0; bod_ok = 1'b1; wdt = 1'b0;
      maddr = 16'h0000; mdl = 8'hc9; spd = 1'b1;
      cyc(12);
      @(posedge clk_sys_i);
      srst_i <= 1'b0;
      por_ok <= 1'b1;
      wt(0, 1'b0, 20);
      cyc(1);
      check(rdata, 8'hc9);
      check(cause, 2'h0);
      check({xpd, rpd}, 2'b10);
      // every slower rate on the 16 MHz source
      for (int c = 7; c >= 1; c--) begin
         wr(8'hc6, {2'b11, 3'(c), 3'b000});
         tick_gap(2 << c);
      end
      @(posedge clk_sys_i);
      unused_oscillator_power_down <= 1'b0;
      cyc(8);
      check({xpd, rpd}, 2'b00);
      // crystal select, held off until stable
      wr(8'hc6, 8'h88);
      cyc(20);
      check(use_rc, 1'b1);
      @(posedge clk_sys_i);
      xstb <= 1'b1;
      wt(1, 1'b0, 60);
      check(n > GUARD, 1'b1);
      spd = 1'b0;
      cyc(1);
      check(rdata[0], 1'b0);
      wr(8'hc6, 8'h80);
      tick_gap(2);
      wr(8'hc6, 8'h08);
      check(lfsel, 1'b1);
      wr(8'hc7, 8'h40);
      // unused RC stopped on crystal, then revived by selecting it
      @(posedge clk_sys_i);
      unused_oscillator_power_down <= 1'b1;
      cyc(4);
      check({xpd, rpd}, 2'b01);
      wr(8'hc6, 8'h48);
      check(rpd, 1'b0);
      wt(1, 1'b1, 60);
      spd = 1'b1;
      wr(8'hc6, 8'h08);
      check(lfsel, 1'b0);
      // deep mode entry and return
      @(posedge clk_sys_i);
      d_in <= 1'b1;
      @(posedge clk_sys_i);
      d_in <= 1'b0;
      #1;
      check({flush, wclr}, 2'b11);
      @(posedge clk_sys_i);
      d_out <= 1'b1;
      @(posedge clk_sys_i);
      d_out <= 1'b0;
      mdl[7] = 1'b1;
      cyc(2);
      check(rdata, {mdl[7:3], 2'b00, spd});
      // retention map, calibration busy meanwhile
      @(posedge clk_sys_i);
      busy <= 1'b1;
      for (int i = 0; i < 24; i++) begin
         @(posedge clk_sys_i);
         maddr <= (i < 8) ? edges[i] : 16'($random(seed));
         if (i == 4) caldis <= 1'b1;
         cyc(1);
         check(kept, maddr >= 16'hf000 &&
            !(maddr >= 16'hfd56 && maddr <= 16'hfeff));
      end
      // disable came while busy: calibration runs on until idle
      check(cal, 1'b1);
      @(posedge clk_sys_i);
      busy <= 1'b0;
      cyc(4);
      check(cal, 1'b0);
      // each reset source in turn
      for (int s = 0; s < 4; s++) begin
         @(posedge clk_sys_i);
         rst_n <= (s != 0);
         por_ok <= (s != 1);
         bod_ok <= (s != 2);
         wdt <= (s == 3);
         cyc(6);
         check(crst, 1'b1);
         check(pull, 1'b1);
         @(posedge clk_sys_i);
         rst_n <= 1'b1;
         por_ok <= 1'b1;
         bod_ok <= 1'b1;
         wdt <= 1'b0;
         wt(0, 1'b0, 20);
         cyc(1);
         mdl = 8'hc9;
         check(cause, causes[s]);
         check(rdata, 8'hc9);
         check(pc, 16'h0000);
      end
      results();
   end
endmodule : crpc_clock_reset_ctrl_tb
